// ### rtl/eep_target.sv
`timescale 1ns/1ps
`include "eep_defines.svh"
module eep_target #(
  parameter int WR_CYC = `EEP_TWR_CYC
) (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst,
  // Two-wire bus
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda,
  output logic o_sda_oe_n,
  // Straps and protection
  input wire logic i_chip_select_strap_0,
  input wire logic i_chip_select_strap_1,
  input wire logic i_chip_select_strap_2,
  input wire logic i_wp,
  // Status
  output logic o_standby
);
  import eep_pkg::*;

  localparam int AW = `EEP_ADDR_W;
  localparam int PW = `EEP_PAGE_W;
  // Pin synchronisers: scl, sda, wp, straps
  logic [5:0] pin_in;
  logic [5:0] s1_reg;
  logic [5:0] s2_reg;
  logic [5:0] s3_reg;
  logic [5:0] filt_reg;
  // Previous filtered scl and sda
  logic scl_d_reg;
  logic sda_d_reg;
  // Protocol state
  eep_state_t st_reg;
  logic [3:0] bitcnt_reg;
  logic nine_reg;
  logic [7:0] sh_reg;
  logic [7:0] rd_sh_reg;
  logic mack_reg;
  logic [AW-1:0] addr_reg;
  // Page buffer
  logic [7:0] pbuf [0:(1<<PW)-1];
  logic [(1<<PW)-1:0] pvalid_reg;
  logic wr_any_reg;
  // Array
  logic [7:0] mem [0:(1<<AW)-1];
  // Write timer
  logic busy_reg;
  logic [`EEP_TMR_W-1:0] tmr_reg;
  // Decoded events
  logic scl_f;
  logic sda_f;
  logic wp_f;
  logic scl_rise;
  logic scl_fall;
  logic start_ev;
  logic stop_ev;
  logic match;
  assign pin_in = {i_chip_select_strap_2, i_chip_select_strap_1,
                   i_chip_select_strap_0, i_wp, i_sda, i_scl};

  // Three flops per pin, level taken when second and third agree
  for (genvar g = 0; g < 6; g++) begin : g_sync
    always_ff @(posedge i_clk_sys or posedge i_rst)
    begin
      if (i_rst)
      begin
        s1_reg[g] <= 1'b1;
        s2_reg[g] <= 1'b1;
        s3_reg[g] <= 1'b1;
        filt_reg[g] <= 1'b1;
      end
      else
      begin
        s1_reg[g] <= pin_in[g];
        s2_reg[g] <= s1_reg[g];
        s3_reg[g] <= s2_reg[g];
        // Glitch rejected until two stages agree
        if (s2_reg[g] == s3_reg[g])
          filt_reg[g] <= s3_reg[g];
      end
    end
  end

  assign scl_f = filt_reg[0];
  assign sda_f = filt_reg[1];
  assign wp_f = filt_reg[2];
  // Edge history of the bus lines
  always_ff @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
    begin
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
    end
    else
    begin
      scl_d_reg <= scl_f;
      sda_d_reg <= sda_f;
    end
  end

  assign scl_rise = scl_f & ~scl_d_reg;
  assign scl_fall = ~scl_f & scl_d_reg;
  // SDA edge with SCL steady high is a condition, not data
  assign start_ev = scl_f & scl_d_reg & sda_d_reg & ~sda_f;
  assign stop_ev = scl_f & scl_d_reg & ~sda_d_reg & sda_f;
  // Type code, straps; silent while the write runs
  assign match = (sh_reg[7:4] == `EEP_TYPE_CODE)
    && (sh_reg[3:1] == filt_reg[5:3]) && !busy_reg;
  // Protocol engine
  always_ff @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
    begin
      st_reg <= EEP_IDLE;
      bitcnt_reg <= 4'h0;
      nine_reg <= 1'b0;
      sh_reg <= 8'h00;
      rd_sh_reg <= 8'h00;
      mack_reg <= 1'b0;
      addr_reg <= '0;
      o_sda_oe_n <= `EEP_OE_REL;
      wr_any_reg <= 1'b0;
      pvalid_reg <= '0;
    end
    else if (start_ev)
    begin
      // Any start, repeated or not, restarts word capture
      st_reg <= EEP_DEV;
      bitcnt_reg <= 4'h0;
      nine_reg <= 1'b0;
      o_sda_oe_n <= `EEP_OE_REL;
      // Abandoned page data dropped, not while committing
      if (!busy_reg)
      begin
        wr_any_reg <= 1'b0;
        pvalid_reg <= '0;
      end
    end
    else if (stop_ev)
    begin
      st_reg <= EEP_IDLE;
      bitcnt_reg <= 4'h0;
      nine_reg <= 1'b0;
      o_sda_oe_n <= `EEP_OE_REL;
    end
    else if (st_reg != EEP_IDLE)
    begin
      if (scl_rise)
      begin
        // Data bits in, or ninth clock sampled
        if (bitcnt_reg != `EEP_BIT_LAST)
        begin
          sh_reg <= {sh_reg[6:0], sda_f};
          bitcnt_reg <= bitcnt_reg + 4'h1;
        end
        else
        begin
          nine_reg <= 1'b1;
          mack_reg <= ~sda_f;
        end
      end
      else if (scl_fall)
      begin
        if (bitcnt_reg == `EEP_BIT_LAST && nine_reg)
        begin
          // End of ninth clock: release, maybe send next byte
          nine_reg <= 1'b0;
          bitcnt_reg <= 4'h0;
          o_sda_oe_n <= `EEP_OE_REL;
          if (st_reg == EEP_RD)
          begin
            // Own ack after device word reads back as low here
            if (mack_reg)
            begin
              o_sda_oe_n <= mem[addr_reg][7];
              rd_sh_reg <= {mem[addr_reg][6:0], 1'b0};
              addr_reg <= addr_reg + 1'b1;
            end
            else
              st_reg <= EEP_IDLE;
          end
        end
        else if (bitcnt_reg == `EEP_BIT_LAST)
        begin
          // End of eighth bit: handle the word
          unique case (st_reg)
            EEP_IDLE: ;
            EEP_DEV:
            begin
              if (match)
              begin
                o_sda_oe_n <= 1'b0;
                st_reg <= sh_reg[0] ? EEP_RD : EEP_AHI;
              end
              else
                st_reg <= EEP_IDLE;
            end
            EEP_AHI:
            begin
              // Bits above the array width are ignored
              addr_reg[AW-1:8] <= sh_reg[AW-9:0];
              o_sda_oe_n <= 1'b0;
              st_reg <= EEP_ALO;
            end
            EEP_ALO:
            begin
              addr_reg[7:0] <= sh_reg;
              o_sda_oe_n <= 1'b0;
              st_reg <= EEP_WR;
            end
            EEP_WR:
            begin
              o_sda_oe_n <= 1'b0;
              // Protected bytes are acked but not kept
              if (!wp_f)
              begin
                pbuf[addr_reg[PW-1:0]] <= sh_reg;
                pvalid_reg[addr_reg[PW-1:0]] <= 1'b1;
                wr_any_reg <= 1'b1;
              end
              addr_reg[PW-1:0] <= addr_reg[PW-1:0] + 5'h1;
            end
            EEP_RD: o_sda_oe_n <= `EEP_OE_REL;
          endcase
        end
        else if (st_reg == EEP_RD)
        begin
          // Next read bit, zero pulls low only
          o_sda_oe_n <= rd_sh_reg[7];
          rd_sh_reg <= {rd_sh_reg[6:0], 1'b0};
        end
      end
    end
  end

  // Self-timed write, commits one page byte per early cycle
  always_ff @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
    begin
      busy_reg <= 1'b0;
      tmr_reg <= '0;
    end
    else if (!busy_reg)
    begin
      tmr_reg <= '0;
      if (stop_ev && st_reg == EEP_WR && wr_any_reg)
        busy_reg <= 1'b1;
    end
    else
    begin
      tmr_reg <= tmr_reg + 1'b1;
      if (tmr_reg == `EEP_TMR_W'(WR_CYC - 1))
        busy_reg <= 1'b0;
    end
  end

  // Array update from the page buffer
  always_ff @(posedge i_clk_sys)
  begin
    if (busy_reg && tmr_reg < `EEP_TMR_W'(1 << PW) && pvalid_reg[tmr_reg[PW-1:0]])
      mem[{addr_reg[AW-1:PW], tmr_reg[PW-1:0]}] <= pbuf[tmr_reg[PW-1:0]];
  end

  // Status and fixed low drive value
  always_ff @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_standby <= 1'b1;
      o_sda <= 1'b0;
    end
    else
    begin
      o_standby <= (st_reg == EEP_IDLE) && !busy_reg;
      o_sda <= 1'b0;
    end
  end
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);

  // End of an eighth bit
  sequence s_byte_end;
    scl_fall && !start_ev && !stop_ev && bitcnt_reg == `EEP_BIT_LAST && !nine_reg;
  endsequence

  a_start_dev: assert property (start_ev |=> st_reg == EEP_DEV && bitcnt_reg == 4'h0)
    else $error("start not taken");
  a_stop_idle: assert property (stop_ev |=> st_reg == EEP_IDLE ##2 o_standby || busy_reg)
    else $error("stop not taken");
  a_ack_match: assert property (s_byte_end ##0 st_reg == EEP_DEV && match |=> !o_sda_oe_n)
    else $error("no ack on match");
  a_nack_miss: assert property (s_byte_end ##0 st_reg == EEP_DEV && !match
    |=> o_sda_oe_n && st_reg == EEP_IDLE)
    else $error("ack on mismatch");
  a_busy_silent: assert property (busy_reg |-> o_sda_oe_n)
    else $error("ack while writing");
  a_wp_guard: assert property ($rose(wr_any_reg) |-> $past(!wp_f))
    else $error("write while protected");
  a_page_wrap: assert property (s_byte_end ##0 st_reg == EEP_WR
    |=> addr_reg[PW-1:0] == $past(addr_reg[PW-1:0]) + 5'h1
    && addr_reg[AW-1:PW] == $past(addr_reg[AW-1:PW]))
    else $error("page wrap wrong");
  a_drive_when: assert property (!o_sda_oe_n |-> bitcnt_reg == `EEP_BIT_LAST
    || st_reg == EEP_RD)
    else $error("drive outside slot");
  a_busy_span: assert property ($rose(busy_reg) |-> busy_reg [*8])
    else $error("write cycle too short");
  a_bit_range: assert property (bitcnt_reg <= `EEP_BIT_LAST)
    else $error("bit count overflow");
endmodule : eep_target

// ### rtl/eep_defines.svh
`ifndef EEP_DEFINES_SVH
`define EEP_DEFINES_SVH
// Byte address width of the larger array variant
`define EEP_ADDR_W 13
// Bits of the byte address inside one page
`define EEP_PAGE_W 5
// Fixed type code in the top nibble of the device address word
`define EEP_TYPE_CODE 4'ha
// Bit count at the end of a word
`define EEP_BIT_LAST 4'h8
// Nonvolatile write time in ms and system clock in kHz
`define EEP_TWR_MS 5
`define EEP_CLK_KHZ 200000
// Write cycle length in clock cycles
`define EEP_TWR_CYC (`EEP_TWR_MS * `EEP_CLK_KHZ)
// Width of the write timer
`define EEP_TMR_W 20
// Released level of the data pin enable
`define EEP_OE_REL 1'b1
`endif

// ### rtl/eep_pkg.sv
package eep_pkg;
  // Protocol states, one-hot
  typedef enum logic [5:0] {
    EEP_IDLE = 6'h01,
    EEP_DEV = 6'h02,
    EEP_AHI = 6'h04,
    EEP_ALO = 6'h08,
    EEP_WR = 6'h10,
    EEP_RD = 6'h20
  } eep_state_t;
endpackage : eep_pkg

// ### bench/eep_ctl_model.sv
`timescale 1ns/1ps
// Bus controller model; SCL stands high between frames
module eep_ctl_model (
  // Resolved data wire
  input wire logic i_sda,
  // Controller drives, one means released
  output logic o_scl,
  output logic o_sda
);
  // Idle bus
  initial
  begin
    o_scl = 1'b1;
    o_sda = 1'b1;
  end
  // Start or repeated start, SDA falls mid SCL high
  task automatic start();
    o_sda = 1'b1;
    #20;
    o_scl = 1'b1;
    #12;
    o_sda = 1'b0;
    #12;
    o_scl = 1'b0;
    #20;
  endtask : start
  // Stop, SDA rises mid SCL high, clock then stays high
  task automatic stop();
    o_sda = 1'b0;
    #20;
    o_scl = 1'b1;
    #12;
    o_sda = 1'b1;
    #12;
  endtask : stop
  // One bit, 64 ns period; data moves only in the low phase
  task automatic clk_bit(input logic b, output logic r);
    o_sda = b;
    #20;
    o_scl = 1'b1;
    #22;
    r = i_sda;
    #2;
    o_scl = 1'b0;
    #20;
  endtask : clk_bit
  // Word MSB first, then the ninth bit
  task automatic xfer(input logic [7:0] d, input logic ack_in,
                      output logic [7:0] q, output logic ack_out);
    for (int i = 7; i >= 0; i--)
      clk_bit(d[i], q[i]);
    clk_bit(ack_in, ack_out);
  endtask : xfer
endmodule : eep_ctl_model

// ### bench/eep_target_test.sv
`timescale 1ns/1ps
`include "eep_defines.svh"
// Compare and count
`define CHK(nm, exp, got) \
  begin \
    n_compared++; \
    if ((got) !== (exp)) \
    begin \
      n_fail++; \
      $display("[FAIL] %s expected %h seen %h", nm, exp, got); \
    end \
  end
module eep_target_test;
  logic clk;
  logic rst;
  logic wp;
  logic [2:0] straps;
  logic scl;
  logic ctl_sda;
  logic dut_sda;
  logic oe_n;
  logic o_standby;
  wire logic sda_w;
  int n_fail = 0;
  int n_compared = 0;
  // Shared data wire: target level while it drives, else controller level
  assign sda_w = oe_n ? ctl_sda : dut_sda;
  // 200 MHz system clock
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  eep_target #(.WR_CYC(200)) DUT (
    .i_clk_sys(clk), .i_rst(rst), .i_scl(scl), .i_sda(sda_w),
    .o_sda(dut_sda), .o_sda_oe_n(oe_n),
    .i_chip_select_strap_0(straps[0]), .i_chip_select_strap_1(straps[1]),
    .i_chip_select_strap_2(straps[2]), .i_wp(wp), .o_standby(o_standby));
  eep_ctl_model ctl (.i_sda(sda_w), .o_scl(scl), .o_sda(ctl_sda));
  // Device word for the strap setting
  function automatic logic [7:0] dev(input logic rw);
    return {`EEP_TYPE_CODE, straps, rw};
  endfunction : dev
  // Controller writes a byte, a is the ninth bit seen
  task automatic wb(input logic [7:0] d, output logic a);
    logic [7:0] q;
    ctl.xfer(d, 1'b1, q, a);
  endtask : wb
  // Start, write device word, two address bytes
  task automatic send_addr(input logic [15:0] ad);
    logic a0, a1, a2;
    ctl.start();
    wb(dev(1'b0), a0);
    wb(ad[15:8], a1);
    wb(ad[7:0], a2);
    `CHK("addr ack", 3'b000, {a0, a1, a2})
  endtask : send_addr
  // Dummy write then repeated start for read
  task automatic open_read(input logic [15:0] ad);
    logic a;
    send_addr(ad);
    ctl.start();
    wb(dev(1'b1), a);
    `CHK("read ack", 1'b0, a)
  endtask : open_read
  // Busy after stop, nack polls, then ack
  task automatic wait_done();
    logic a;
    #50;
    `CHK("busy", 1'b0, o_standby)
    ctl.start();
    wb(dev(1'b0), a);
    `CHK("poll nack", 1'b1, a)
    for (int i = 0; i < 40 && a; i++)
    begin
      ctl.start();
      wb(dev(1'b0), a);
    end
    `CHK("poll ack", 1'b0, a)
    ctl.stop();
  endtask : wait_done
  // Wrong straps and wrong type code
  task automatic t_mismatch();
    logic a;
    ctl.start();
    wb({`EEP_TYPE_CODE, 3'b100, 1'b0}, a);
    `CHK("strap nack", 1'b1, a)
    ctl.start();
    wb({4'h5, straps, 1'b0}, a);
    `CHK("type nack", 1'b1, a)
    ctl.stop();
    `CHK("standby", 1'b1, o_standby)
    `CHK("drive level", 1'b0, dut_sda)
  endtask : t_mismatch
  // Byte write at zero
  task automatic t_byte();
    logic a;
    send_addr(16'h0000);
    wb(8'h5a, a);
    `CHK("data ack", 1'b0, a)
    ctl.stop();
    wait_done();
  endtask : t_byte
  // 34 bytes from page offset 30; top bits of high byte ignored
  task automatic t_page();
    logic a;
    send_addr(16'hfffe);
    for (int k = 0; k < 34; k++)
    begin
      wb(8'h40 + k[7:0], a);
      `CHK("page ack", 1'b0, a)
    end
    ctl.stop();
    wait_done();
  endtask : t_page
  // Read the whole page, then the counter wraps to zero
  task automatic t_seq();
    logic a;
    logic [7:0] q;
    int k;
    open_read(16'h1fe0);
    for (int j = 0; j < 32; j++)
    begin
      ctl.xfer(8'hff, j == 31, q, a);
      k = (j - 30) & 31;
      if (k < 2)
        k += 32;
      `CHK("page data", 8'h40 + k[7:0], q)
    end
    ctl.stop();
    ctl.start();
    wb(dev(1'b1), a);
    ctl.xfer(8'hff, 1'b1, q, a);
    ctl.stop();
    `CHK("wrap read", 8'h5a, q)
  endtask : t_seq
  // Protected write is dropped
  task automatic t_wp();
    logic a;
    logic [7:0] q;
    @(negedge clk);
    wp = 1'b1;
    send_addr(16'h0000);
    wb(8'ha5, a);
    ctl.stop();
    #50;
    `CHK("wp idle", 1'b1, o_standby)
    @(negedge clk);
    wp = 1'b0;
    open_read(16'h0000);
    ctl.xfer(8'hff, 1'b1, q, a);
    ctl.stop();
    `CHK("wp kept", 8'h5a, q)
  endtask : t_wp
  // Abort a read while the device holds SDA low, then recover
  task automatic t_swreset();
    logic a;
    logic [7:0] q;
    open_read(16'h0000);
    for (int i = 0; i < 2; i++)
      ctl.clk_bit(1'b1, a);
    ctl.start();
    for (int i = 0; i < 9; i++)
      ctl.clk_bit(1'b1, a);
    ctl.start();
    ctl.stop();
    open_read(16'h0000);
    ctl.xfer(8'hff, 1'b1, q, a);
    ctl.stop();
    `CHK("after recovery", 8'h5a, q)
  endtask : t_swreset
  // Verdict and end of run
  task automatic wrap_up();
    if (n_fail == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : wrap_up
  // Main sequence
  initial
  begin
    rst = 1'b1;
    wp = 1'b0;
    straps = 3'b101;
    repeat (4) @(negedge clk);
    rst = 1'b0;
    repeat (8) @(negedge clk);
    t_mismatch();
    t_byte();
    t_page();
    t_seq();
    t_wp();
    t_swreset();
    wrap_up();
  end
  // Watchdog, well past the expected run
  initial
  begin
    #300us;
    n_fail++;
    wrap_up();
  end
endmodule : eep_target_test
